/* rtl/ssc_strap_config.sv */
// standalone strap configuration loader with apb view and interrupt
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"

module ssc_strap_config #(
  parameter logic [`SSC_REST_CNT_W-1:0] REST_CYCLES =
    `SSC_REST_CNT_W'(`SSC_REST_CYCLES)
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // board straps, mode pins and step pin
  input  wire logic        interface_select_pin,
  input  wire logic        step_dir_mode_pin,
  input  wire logic        resolution_strap_bit0,
  input  wire logic        resolution_strap_bit1,
  input  wire logic        current_strap_bit0,
  input  wire logic        current_strap_bit1,
  input  wire logic        current_strap_bit2,
  input  wire logic        chopper_strap,
  input  wire logic        hold_reduction_strap,
  input  wire logic        stepPin,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // decoded settings to the driver core
  output logic             standaloneMode,
  output logic             spiPortEnable,
  output logic             singleWireEnable,
  output logic [3:0]       resolution_code,
  output logic [4:0]       run_current_code,
  output logic [4:0]       hold_current_code,
  output logic [3:0]       off_time_setting,
  output logic             quietChopperEnable,
  output logic             first_diag_error_select,
  output logic             second_diag_index_select,
  output logic             restReady,
  // interrupt
  output logic             irq
);
  import ssc_pkg::*;

  // ========================================================================
  // pin synchronisation
  ssc_strap_if #(.W(`SSC_PIN_W)) pinBus ();

  assign pinBus.raw = {stepPin, step_dir_mode_pin, interface_select_pin,
                       hold_reduction_strap, chopper_strap,
                       current_strap_bit2, current_strap_bit1,
                       current_strap_bit0, resolution_strap_bit1,
                       resolution_strap_bit0};

  ssc_strap_sync #(.W(`SSC_PIN_W)) pinSync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pins    (pinBus.sync)
  );

  logic [`SSC_PIN_W-1:0] pinLvl;
  assign pinLvl = pinBus.synced;

  // ========================================================================
  // strap decode
  function automatic logic [4:0] ssc_run_decode(input logic [2:0] sel);
    logic [4:0] code;
    code = `SSC_RUN_BASE + {1'b0, sel, 1'b0};
    if (sel == 3'h7) begin
      code = `SSC_RUN_MAX;
    end
    return code;
  endfunction

  ssc_state_t stReg;
  ssc_state_t stNext;

  logic       apbSetup;
  logic       apbWrite;
  logic       addrHit;
  logic [2:0] irqSet;
  logic [2:0] irqClr;
  logic       snapStandalone;
  logic       stepRise;
  logic       strapMoved;

  // ========================================================================
  // apb decode
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite;
  assign addrHit  = (paddr == `SSC_CONFIG_OFS) ||
                    (paddr == `SSC_STRAPS_OFS) ||
                    (paddr == `SSC_IRQ_STATUS_OFS) ||
                    (paddr == `SSC_IRQ_MASK_OFS);

  // the snapshot carries both mode pins as well
  assign snapStandalone = !stReg.strapSnap[`SSC_PIN_IFSEL] &&
                          stReg.strapSnap[`SSC_PIN_SDMODE];
  assign stepRise   = pinLvl[`SSC_PIN_STEP] && !stReg.stepPrev;
  assign strapMoved = (stReg.phase == SSC_HOLD) &&
                      (pinLvl[`SSC_STRAP_W-1:0] != stReg.strapSnap);

  always_comb begin
    stNext   = stReg;
    irqSet   = '0;
    irqClr   = '0;
    stNext.stepPrev = pinLvl[`SSC_PIN_STEP];

    // load sequencer: wait for the synchroniser to fill, latch once
    case (stReg.phase)
      SSC_WAIT: begin
        stNext.settleCnt = stReg.settleCnt + 2'h1;
        if (stReg.settleCnt == `SSC_SETTLE_CYCLES) begin
          stNext.phase     = SSC_LATCH;
          stNext.strapSnap = pinLvl[`SSC_STRAP_W-1:0];
        end
      end
      SSC_LATCH: begin
        stNext.phase      = SSC_HOLD;
        stNext.standalone = snapStandalone;
        irqSet[`SSC_IRQ_LOADED] = 1'b1;
        if (snapStandalone) begin
          stNext.diag0Err   = 1'b1;
          stNext.diag1Index = 1'b1;
          stNext.resCode = `SSC_RES_BASE -
            {2'b00, stReg.strapSnap[`SSC_PIN_RES1],
             stReg.strapSnap[`SSC_PIN_RES0]};
          stNext.runCur = ssc_run_decode(
            stReg.strapSnap[`SSC_PIN_CUR2:`SSC_PIN_CUR0]);
          if (stReg.strapSnap[`SSC_PIN_HOLD]) begin
            stNext.holdCur = ssc_run_decode(
              stReg.strapSnap[`SSC_PIN_CUR2:`SSC_PIN_CUR0]) >> 1;
          end else begin
            stNext.holdCur = ssc_run_decode(
              stReg.strapSnap[`SSC_PIN_CUR2:`SSC_PIN_CUR0]);
          end
          if (stReg.strapSnap[`SSC_PIN_CHOP]) begin
            stNext.quiet   = 1'b1;
            stNext.offTime = `SSC_OFF_TIME_SETTING_RESET;
          end else begin
            stNext.quiet   = 1'b0;
            stNext.offTime = `SSC_OFF_TIME_SETTING_CYCLE;
          end
        end
      end
      SSC_HOLD: begin
        // settings stay frozen until the next reset
        stNext.phase = SSC_HOLD;
      end
      default: begin
        stNext.phase = SSC_WAIT;
      end
    endcase

    // standstill timer: restarts on every rising step edge, quiet mode only
    if (stReg.phase == SSC_HOLD && stReg.quiet) begin
      if (stepRise) begin
        stNext.restCnt  = '0;
        stNext.restDone = 1'b0;
      end else if (!stReg.restDone) begin
        if (stReg.restCnt >= REST_CYCLES - `SSC_REST_CNT_W'(1)) begin
          stNext.restDone = 1'b1;
          irqSet[`SSC_IRQ_REST_READY] = 1'b1;
        end else begin
          stNext.restCnt = stReg.restCnt + `SSC_REST_CNT_W'(1);
        end
      end
    end

    // a strap moved after the snapshot: flagged, never applied
    if (strapMoved) begin
      irqSet[`SSC_IRQ_STRAP_MOVE] = 1'b1;
    end

    // register writes
    if (apbWrite) begin
      if (paddr == `SSC_IRQ_STATUS_OFS) begin
        irqClr = pwdata[`SSC_IRQ_W-1:0];
      end
      if (paddr == `SSC_IRQ_MASK_OFS) begin
        stNext.irqMask = pwdata[`SSC_IRQ_W-1:0];
      end
    end
    // a set in the clearing cycle wins
    stNext.irqStatus = (stReg.irqStatus & ~irqClr) | irqSet;

    // read data is captured in the setup cycle
    if (apbSetup) begin
      stNext.rdata  = '0;
      stNext.slvErr = !addrHit;
      if (!pwrite) begin
        case (paddr)
          `SSC_CONFIG_OFS: begin
            stNext.rdata[`SSC_F_RES_LSB +: 4]  = stReg.resCode;
            stNext.rdata[`SSC_F_RUN_LSB +: 5]  = stReg.runCur;
            stNext.rdata[`SSC_F_HOLD_LSB +: 5] = stReg.holdCur;
            stNext.rdata[`SSC_F_OFF_TIME_SETTING_LSB +: 4] = stReg.offTime;
            stNext.rdata[`SSC_F_QUIET_BIT]     = stReg.quiet;
            stNext.rdata[`SSC_F_FIRST_DIAG_OUTPUT_BIT]     = stReg.diag0Err;
            stNext.rdata[`SSC_F_SECOND_DIAG_OUTPUT_BIT]     = stReg.diag1Index;
            stNext.rdata[`SSC_F_STANDALONE]    = stReg.standalone;
            stNext.rdata[`SSC_F_LOADED]        = stReg.phase == SSC_HOLD;
          end
          `SSC_STRAPS_OFS: begin
            stNext.rdata[`SSC_STRAP_W-1:0] = stReg.strapSnap;
          end
          `SSC_IRQ_STATUS_OFS: begin
            stNext.rdata[`SSC_IRQ_W-1:0] = stReg.irqStatus;
          end
          `SSC_IRQ_MASK_OFS: begin
            stNext.rdata[`SSC_IRQ_W-1:0] = stReg.irqMask;
          end
          default: begin
            stNext.rdata = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stReg            <= '0;
      stReg.phase      <= SSC_WAIT;
      stReg.resCode    <= `SSC_RES_RESET;
      stReg.runCur     <= `SSC_RUN_RESET;
      stReg.holdCur    <= `SSC_HOLD_RESET;
      stReg.offTime    <= `SSC_OFF_TIME_SETTING_RESET;
      stReg.irqMask    <= `SSC_MASK_RESET;
    end else begin
      stReg <= stNext;
    end
  end

  // ========================================================================
  // outputs
  assign pready  = 1'b1;
  assign prdata  = stReg.rdata;
  assign pslverr = stReg.slvErr;

  assign standaloneMode           = stReg.standalone;
  // serial ports stay live until the straps say otherwise
  assign spiPortEnable            = !stReg.standalone;
  assign singleWireEnable         = !stReg.standalone;
  assign resolution_code          = stReg.resCode;
  assign run_current_code         = stReg.runCur;
  assign hold_current_code        = stReg.holdCur;
  assign off_time_setting         = stReg.offTime;
  assign quietChopperEnable       = stReg.quiet;
  assign first_diag_error_select  = stReg.diag0Err;
  assign second_diag_index_select = stReg.diag1Index;
  assign restReady                = stReg.restDone;
  assign irq                      = |(stReg.irqStatus & stReg.irqMask);

  // ========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic loaded;
  assign loaded = stReg.phase == SSC_HOLD;

  a_standalone_mode: assert property (
    (stReg.phase == SSC_LATCH) |=> standaloneMode ==
      (!stReg.strapSnap[`SSC_PIN_IFSEL] && stReg.strapSnap[`SSC_PIN_SDMODE])
  ) else $error("standalone mode not taken from mode pins");

  a_serial_off: assert property (
    (loaded && standaloneMode) |-> (!spiPortEnable && !singleWireEnable)
  ) else $error("serial ports live in standalone mode");

  a_diag_error: assert property (
    (loaded && standaloneMode) |-> first_diag_error_select
  ) else $error("first diag error select not forced");

  a_diag_index: assert property (
    (loaded && standaloneMode) |-> second_diag_index_select
  ) else $error("second diag index select not forced");

  a_res_decode: assert property (
    (stReg.phase == SSC_LATCH && snapStandalone) |=>
      resolution_code == 4'h5 - {2'b00, $past(stReg.strapSnap[1:0])}
  ) else $error("resolution code wrong for straps");

  a_run_decode: assert property (
    (stReg.phase == SSC_LATCH && snapStandalone &&
     stReg.strapSnap[4:2] == 3'h7) |=> run_current_code == 5'h1F
  ) else $error("top current strap not full run current");

  a_chop_cycle: assert property (
    (loaded && standaloneMode && !stReg.strapSnap[`SSC_PIN_CHOP]) |->
      (off_time_setting == 4'h3 && !quietChopperEnable)
  ) else $error("cycle chopper not set up");

  a_chop_quiet: assert property (
    (loaded && standaloneMode && stReg.strapSnap[`SSC_PIN_CHOP]) |->
      quietChopperEnable
  ) else $error("quiet chopper not enabled");

  a_hold_equal: assert property (
    (loaded && standaloneMode && !stReg.strapSnap[`SSC_PIN_HOLD]) |->
      hold_current_code == run_current_code
  ) else $error("hold current differs from run");

  a_hold_half: assert property (
    (loaded && standaloneMode && stReg.strapSnap[`SSC_PIN_HOLD]) |->
      hold_current_code == (run_current_code >> 1)
  ) else $error("hold current not half run");

  a_settings_frozen: assert property (
    loaded |=> ($stable(resolution_code) && $stable(run_current_code) &&
                $stable(hold_current_code) && $stable(standaloneMode))
  ) else $error("settings moved after load");

  a_load_time: assert property (
    $fell(reset) |-> ##[1:6] loaded
  ) else $error("load not done after reset release");

  c_standalone_quiet: cover property (
    loaded && standaloneMode && quietChopperEnable);
  c_rest_ready: cover property ($rose(restReady));
  c_strap_moved: cover property (irqSet[`SSC_IRQ_STRAP_MOVE] && irq);

endmodule

`default_nettype wire

/* rtl/ssc_params.svh */
// offsets, field positions, reset values and timing counts of the strap loader
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// ==========================================================================
// register byte offsets
`define SSC_CONFIG_OFS      12'h000
`define SSC_STRAPS_OFS      12'h004
`define SSC_IRQ_STATUS_OFS  12'h008
`define SSC_IRQ_MASK_OFS    12'h00C

// ==========================================================================
// config register field positions
`define SSC_F_RES_LSB       0
`define SSC_F_RUN_LSB       4
`define SSC_F_HOLD_LSB      9
`define SSC_F_OFF_TIME_SETTING_LSB      14
`define SSC_F_QUIET_BIT     18
`define SSC_F_FIRST_DIAG_OUTPUT_BIT     19
`define SSC_F_SECOND_DIAG_OUTPUT_BIT     20
`define SSC_F_STANDALONE    21
`define SSC_F_LOADED        22

// irq status bits
`define SSC_IRQ_LOADED      0
`define SSC_IRQ_STRAP_MOVE  1
`define SSC_IRQ_REST_READY  2
`define SSC_IRQ_W           3

// ==========================================================================
// synchronised pin vector positions
`define SSC_PIN_RES0        0
`define SSC_PIN_RES1        1
`define SSC_PIN_CUR0        2
`define SSC_PIN_CUR1        3
`define SSC_PIN_CUR2        4
`define SSC_PIN_CHOP        5
`define SSC_PIN_HOLD        6
`define SSC_PIN_IFSEL       7
`define SSC_PIN_SDMODE      8
`define SSC_PIN_STEP        9
`define SSC_STRAP_W         9
`define SSC_PIN_W           10

// ==========================================================================
// decoded values and reset values
`define SSC_RES_BASE        4'h5
`define SSC_RUN_BASE        5'h10
`define SSC_RUN_MAX         5'h1F
`define SSC_OFF_TIME_SETTING_CYCLE      4'h3
`define SSC_RES_RESET       4'h0
`define SSC_RUN_RESET       5'h00
`define SSC_HOLD_RESET      5'h00
`define SSC_OFF_TIME_SETTING_RESET      4'h0
`define SSC_MASK_RESET      3'h0

// ==========================================================================
// timing: sync settle and standstill rest before quiet-mode motion
`define SSC_SETTLE_CYCLES   2'h3
`define SSC_CLK_HZ          25000000
`define SSC_REST_TIME_MS    100
`define SSC_REST_CYCLES     ((`SSC_CLK_HZ / 1000) * `SSC_REST_TIME_MS)
`define SSC_REST_CNT_W      22

`endif

/* rtl/ssc_pkg.sv */
// types shared by the strap configuration loader
`default_nettype none
`include "ssc_params.svh"

package ssc_pkg;

  // ========================================================================
  // load sequencer
  typedef enum logic [1:0] {
    SSC_WAIT  = 2'b00,
    SSC_LATCH = 2'b01,
    SSC_HOLD  = 2'b10
  } ssc_phase_t;

  // ========================================================================
  // whole state of the loader
  typedef struct packed {
    ssc_phase_t                   phase;
    logic [1:0]                   settleCnt;
    logic [`SSC_STRAP_W-1:0]      strapSnap;
    logic                         standalone;
    logic [3:0]                   resCode;
    logic [4:0]                   runCur;
    logic [4:0]                   holdCur;
    logic [3:0]                   offTime;
    logic                         quiet;
    logic                         diag0Err;
    logic                         diag1Index;
    logic [`SSC_IRQ_W-1:0]        irqStatus;
    logic [`SSC_IRQ_W-1:0]        irqMask;
    logic [`SSC_REST_CNT_W-1:0]   restCnt;
    logic                         restDone;
    logic                         stepPrev;
    logic [31:0]                  rdata;
    logic                         slvErr;
  } ssc_state_t;

endpackage

`default_nettype wire

/* rtl/ssc_strap_if.sv */
// carries raw pin levels into the synchroniser and the settled levels back
`timescale 1ns/1ps
`default_nettype none

interface ssc_strap_if #(
  parameter int W = 10
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface

`default_nettype wire

/* rtl/ssc_strap_sync.sv */
// two-flop synchroniser for the strap, mode and step pins
`timescale 1ns/1ps
`default_nettype none

module ssc_strap_sync #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  reset,
  // pin levels in, settled levels out
  ssc_strap_if.sync  pins
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssc_sync_state_t;

  ssc_sync_state_t syncReg;
  ssc_sync_state_t syncNext;

  always_comb begin
    syncNext.meta   = pins.raw;
    syncNext.stable = syncReg.meta;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  // only the second stage leaves this module
  assign pins.synced = syncReg.stable;

endmodule

`default_nettype wire

/* verification/ssc_strap_partner.sv */
// board strap levels and step pulse source facing the loader
`timescale 1ns/1ps
`default_nettype none

module ssc_strap_partner #(
  parameter int REST = 20
) (
  // clock
  input  wire logic       sys_clk,
  // levels and step request from the bench
  input  wire logic [8:0] levels,
  input  wire logic       stepReq,
  // board side
  output logic [8:0]      pins,
  output logic            stepPin,
  output logic            stepDone
);
  int   idle = 0;
  logic stepQ = 1'b0;
  logic doneQ = 1'b0;

  // =========================================================================
  // straps are tied levels: the bench sets the mode pins, standalone or not
  assign pins = levels;
  assign stepPin  = stepQ;
  assign stepDone = doneQ;

  // =========================================================================
  // one-cycle step pulse, only after a full rest since the last one
  always @(posedge sys_clk) begin
    doneQ <= 1'b0;
    if (stepQ) begin
      stepQ <= 1'b0;
      doneQ <= 1'b1;
      idle <= 0;
    end else if (stepReq && idle >= REST) begin
      stepQ <= 1'b1;
    end else begin
      idle <= idle + 1;
    end
  end
endmodule

`default_nettype wire

/* verification/tb_standalone_strap_config.sv */
// self-checking bench for the standalone strap loader
`timescale 1ns/1ps
`default_nettype none

module tb_standalone_strap_config;
  import ssc_pkg::*;

  localparam int REST = 20;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [8:0]  levels = 9'h100;
  logic        stepReq = 1'b0;
  logic [8:0]  pins;
  logic        stepPin, stepDone, pready, pslverr, sa, spiEn, swEn;
  logic        quiet, d0, d1, restRdy, irq;
  logic [31:0] prdata;
  logic [3:0]  resO, offO;
  logic [4:0]  runO, holdO;
  logic [15:0] r = 16'h9417;
  int          errorCnt = 0;
  int          nCompared = 0;

  initial forever #20 sys_clk = ~sys_clk;

  ssc_strap_partner #(.REST(REST)) u_far (
    .sys_clk(sys_clk), .levels(levels), .stepReq(stepReq), .pins(pins),
    .stepPin(stepPin), .stepDone(stepDone));

  ssc_strap_config #(.REST_CYCLES(22'(REST))) u_dut (
    .sys_clk(sys_clk), .reset(reset),
    .interface_select_pin(pins[7]), .step_dir_mode_pin(pins[8]),
    .resolution_strap_bit0(pins[0]), .resolution_strap_bit1(pins[1]),
    .current_strap_bit0(pins[2]), .current_strap_bit1(pins[3]),
    .current_strap_bit2(pins[4]), .chopper_strap(pins[5]),
    .hold_reduction_strap(pins[6]), .stepPin(stepPin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .standaloneMode(sa), .spiPortEnable(spiEn), .singleWireEnable(swEn),
    .resolution_code(resO), .run_current_code(runO),
    .hold_current_code(holdO), .off_time_setting(offO),
    .quietChopperEnable(quiet), .first_diag_error_select(d0),
    .second_diag_index_select(d1), .restReady(restRdy), .irq(irq));

  // =========================================================================
  // reference model: expected config word from the pin snapshot
  function automatic logic [31:0] model(input logic [8:0] p);
    int sa = (p[7] == 1'b0 && p[8] == 1'b1);
    int n = p[4:2];
    int run = (n == 7) ? 31 : 16 + 2 * n;
    int hold = p[6] ? run / 2 : run;
    if (sa == 0) return 0;
    return (5 - p[1:0]) | run << 4 | hold << 9
      | (p[5] ? 1 << 18 : 3 << 14) | 7 << 19;
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // =========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report(input string t);
    $display("test %s done: %0d checks, %0d errors", t, nCompared, errorCnt);
  endtask

  task automatic endOfTest;
    $display("compared %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // idle cycle first, so psel never changes twice in one step
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int w = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++w < 16);
    if (w >= 16) errorCnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic boot(input logic [8:0] lv, input int n);
    @(posedge sys_clk);
    reset <= 1'b1;
    levels <= lv;
    repeat (n) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic chkCfg(input logic [8:0] lv);
    logic [31:0] e, rd;
    logic er;
    e = model(lv);
    chk("outputs", {10'h0, sa, d1, d0, quiet, offO, holdO, runO, resO},
        e);
    chk("serial", {spiEn, swEn}, e[21] ? 0 : 3);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    // loaded flag always set once the snapshot is decoded
    chk("config", rd, e | 32'h0040_0000);
    chk("config err", er, 0);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk("straps", rd, {23'h0, lv});
  endtask

  // =========================================================================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic er;
    int k;
    boot(9'h100, 10);
    for (int i = 0; i < 128; i++) begin
      boot({2'b10, i[6:0]}, 2);
      chkCfg({2'b10, i[6:0]});
    end
    report("standalone straps");
    for (int m = 0; m < 4; m++) begin
      if (m == 2) continue;
      r = lfsr(r);
      boot({m[1:0], r[6:0]}, 2);
      chkCfg({m[1:0], r[6:0]});
    end
    report("other modes");
    boot(9'h125, 2);
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk("mask reset", rd, 0);
    chk("irq masked", irq, 0);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk("loaded event", rd[0], 1);
    apb(1'b1, 12'h00C, 32'h1, rd, er);
    repeat (2) @(posedge sys_clk);
    chk("irq raised", irq, 1);
    apb(1'b1, 12'h008, 32'h1, rd, er);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", irq, 0);
    levels <= 9'h15A;
    repeat (4) @(posedge sys_clk);
    chkCfg(9'h125);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk("strap moved", rd[1], 1);
    levels <= 9'h125;
    apb(1'b1, 12'h008, 32'h2, rd, er);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk("moved cleared", rd[1], 0);
    report("interrupt");
    chk("rest ready", restRdy, 1);
    chk("rest event", rd[2], 1);
    stepReq <= 1'b1;
    k = 0;
    do @(posedge sys_clk); while (stepDone !== 1'b1 && ++k < 100);
    stepReq <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("rest restart", restRdy, 0);
    k = 0;
    do @(posedge sys_clk); while (restRdy !== 1'b1 && ++k < 60);
    chk("rest span", k >= 12 && k <= 28, 1);
    report("rest");
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk("unmapped data", rd, 0);
    chk("unmapped err", er, 1);
    apb(1'b1, 12'h000, 32'hFFFFFFFF, rd, er);
    chkCfg(9'h125);
    r = lfsr(r);
    apb(1'b1, 12'h00C, {16'h0, r}, rd, er);
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk("mask rw", rd, r[2:0]);
    report("register access");
    endOfTest;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    errorCnt++;
    endOfTest;
  end
endmodule

`default_nettype wire
